//--- src/npb_map.vh
// constants for the flash pointer/bad-block host sequencer
// assumes a 100 MHz ref_clk and a byte-wide multiplexed flash outside
`ifndef NPB_MAP_VH
`define NPB_MAP_VH
`define NPB_CMD_PTR_A     8'h00
`define NPB_CMD_PTR_B     8'h01
`define NPB_CMD_PTR_C     8'h50
`define NPB_CMD_PROG      8'h80
`define NPB_CMD_CONFIRM   8'h10
`define NPB_CMD_STATUS    8'h70
`define NPB_CMD_RESET     8'hFF
`define NPB_ERASED        8'hFF
`define NPB_MARK_COL      8'h05
`define NPB_BLK_ZERO      16'h0000
`define NPB_CLK_NS        10
`define NPB_FETCH_US      15
`define NPB_RESET_US      5
`define NPB_CEH_NS        100
`define NPB_CRY_NS        50
`define NPB_STROBE_CYC    3
`define NPB_WB_CYC        2
`define NPB_ADDR_CYCLES   4
`define NPB_STAT_FAIL_BIT 0
`endif

//--- src/npb_host.v
// host-side sequencer: pointer commands, page read/program, reset, marker check
// assumes flash pins are synchronous to ref_clk; ready_busy pulled up outside
// How it works
// - hold select high over 100 ns to end
// - scan marker, report bad, never erase it
// - program failure reported for block retirement
// - read data passed out for external correction
// - pointer B issued right before program command
`timescale 1ns/1ps
`include "npb_map.vh"
module npb_host #(
	parameter FETCH_CYC = (`NPB_FETCH_US*1000)/`NPB_CLK_NS,
	parameter ADDR_W    = 32
) (
	input  wire              ref_clk,
	input  wire              rstn,
	input  wire              op_start,
	input  wire [2:0]        op_code,
	input  wire [1:0]        op_area,
	input  wire [ADDR_W-1:0] op_addr,
	input  wire [9:0]        op_len,
	input  wire [7:0]        wr_byte,
	output reg               wr_take,
	output reg  [7:0]        rd_byte,
	output reg               rd_valid,
	output reg               op_busy,
	output reg               op_done,
	output reg               op_fail,
	output reg               blk_bad,
	output reg               chip_en_n,
	output reg               cmd_latch,
	output reg               addr_latch,
	output reg               write_strobe_n,
	output reg               output_strobe_n,
	output reg  [7:0]        io_out,
	output reg               io_oe_n,
	input  wire [7:0]        io_in,
	input  wire              ready_busy
);
	localparam RESET_CYC = (`NPB_RESET_US*1000)/`NPB_CLK_NS;
	localparam CEH_CYC   = (`NPB_CEH_NS+`NPB_CLK_NS-1)/`NPB_CLK_NS + 1;
	localparam CRY_CYC   = (`NPB_CRY_NS+`NPB_CLK_NS-1)/`NPB_CLK_NS;
	// op codes
	localparam OP_READ = 3'd0, OP_PROG = 3'd1, OP_RESET = 3'd2, OP_SCAN = 3'd3;
	// states
	localparam S_IDLE = 4'd0, S_PTR = 4'd1, S_CMD = 4'd2, S_ADDR = 4'd3, S_BUSY = 4'd4;
	localparam S_RDAT = 4'd5, S_WDAT = 4'd6, S_CONF = 4'd7, S_STAT = 4'd8, S_CEH = 4'd9;
	localparam S_ABORT = 4'd10, S_DONE = 4'd11;
	reg [3:0]        st_reg;
	reg [2:0]        op_reg;
	reg [1:0]        ptr_reg;
	reg [ADDR_W-1:0] addr_reg;
	reg [9:0]        len_reg;
	reg [15:0]       tmr_reg;
	reg [2:0]        ph_reg;
	reg [1:0]        ac_reg;
	reg              cmd_done_reg;
	// pointer command for an area code
	function [7:0] ptr_cmd;
		input [1:0] a;
		begin
			ptr_cmd = (a == 2'd1) ? `NPB_CMD_PTR_B :
				(a == 2'd2) ? `NPB_CMD_PTR_C : `NPB_CMD_PTR_A;
		end
	endfunction
	// one write strobe cycle of phases: setup, low, high
	wire strobe_end = (ph_reg == `NPB_STROBE_CYC-1);
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_reg <= S_IDLE; op_reg <= 3'd0; ptr_reg <= 2'd0; addr_reg <= {ADDR_W{1'b0}};
			len_reg <= 10'd0; tmr_reg <= 16'd0; ph_reg <= 3'd0; ac_reg <= 2'd0;
			cmd_done_reg <= 1'b0; wr_take <= 1'b0; rd_byte <= 8'h00; rd_valid <= 1'b0;
			op_busy <= 1'b0; op_done <= 1'b0; op_fail <= 1'b0; blk_bad <= 1'b0;
			chip_en_n <= 1'b1; cmd_latch <= 1'b0; addr_latch <= 1'b0;
			write_strobe_n <= 1'b1; output_strobe_n <= 1'b1; io_out <= 8'h00;
			io_oe_n <= 1'b1;
		end
		else
		begin
			wr_take <= 1'b0;
			rd_valid <= 1'b0;
			op_done <= 1'b0;
			case (st_reg)
			S_IDLE:
			begin
				chip_en_n <= 1'b1;
				io_oe_n <= 1'b1;
				// only start when the flash is ready
				if (op_start && ready_busy)
				begin
					op_reg <= op_code; addr_reg <= op_addr; len_reg <= op_len;
					op_fail <= 1'b0; blk_bad <= 1'b0; op_busy <= 1'b1; ph_reg <= 3'd0;
					// scan reads area C at offset of marker column 517
					ptr_reg <= (op_code == OP_SCAN) ? 2'd2 : op_area;
					st_reg <= (op_code == OP_RESET) ? S_CMD : S_PTR;
				end
			end
			S_PTR, S_CMD, S_CONF:
			begin
				// command cycle; pointer B goes straight before program
				chip_en_n <= 1'b0; cmd_latch <= 1'b1; addr_latch <= 1'b0; io_oe_n <= 1'b0;
				io_out <= (st_reg == S_PTR) ? ptr_cmd(ptr_reg) :
					(st_reg == S_CONF) ? `NPB_CMD_CONFIRM :
					cmd_done_reg ? `NPB_CMD_STATUS :
					(op_reg == OP_RESET) ? `NPB_CMD_RESET :
					(op_reg == OP_PROG) ? `NPB_CMD_PROG : `NPB_CMD_PTR_A;
				write_strobe_n <= !(ph_reg == 3'd1);
				ph_reg <= strobe_end ? 3'd0 : ph_reg + 3'd1;
				// latch drops in the next state, so it holds past the strobe edge
				if (strobe_end)
				begin
					ac_reg <= 2'd0;
					tmr_reg <= 16'd0;
					if (st_reg == S_CONF) st_reg <= S_BUSY;
					else if (st_reg == S_CMD && cmd_done_reg) st_reg <= S_STAT;
					else if (st_reg == S_CMD && op_reg == OP_PROG) st_reg <= S_ADDR;
					else if (st_reg == S_CMD) st_reg <= S_BUSY;
					else if (op_reg == OP_PROG) st_reg <= S_CMD;
					else st_reg <= S_ADDR;
				end
			end
			S_ADDR:
			begin
				cmd_latch <= 1'b0; addr_latch <= 1'b1; io_oe_n <= 1'b0;
				io_out <= (op_reg == OP_SCAN && ac_reg == 2'd0) ? `NPB_MARK_COL :
					addr_reg[ac_reg*8 +: 8];
				write_strobe_n <= !(ph_reg == 3'd1);
				ph_reg <= strobe_end ? 3'd0 : ph_reg + 3'd1;
				if (strobe_end)
				begin
					ac_reg <= ac_reg + 2'd1;
					if (ac_reg == `NPB_ADDR_CYCLES-1)
					begin
						tmr_reg <= 16'd0;
						st_reg <= (op_reg == OP_PROG) ? S_WDAT : S_BUSY;
					end
				end
			end
			S_BUSY:
			begin
				// wait for ready, bounded by fetch or reset time
				io_oe_n <= 1'b1; cmd_latch <= 1'b0; addr_latch <= 1'b0;
				tmr_reg <= tmr_reg + 16'd1;
				// ready ignored until the device has had time to show busy
				if (tmr_reg >= `NPB_WB_CYC && ready_busy)
				begin
					tmr_reg <= 16'd0;
					// a program is followed by a status command
					cmd_done_reg <= (op_reg == OP_PROG);
					if (op_reg == OP_PROG) st_reg <= S_CMD;
					else if (op_reg == OP_RESET) st_reg <= S_CEH;
					else st_reg <= S_RDAT;
				end
				else if (tmr_reg == ((op_reg == OP_RESET) ? RESET_CYC : FETCH_CYC))
				begin
					op_fail <= 1'b1; chip_en_n <= 1'b1; tmr_reg <= 16'd0;
					st_reg <= S_ABORT;
				end
			end
			S_RDAT, S_STAT:
			begin
				// read strobe; data handed out raw for external correction
				// status command was sent through the command states first
				io_oe_n <= 1'b1; addr_latch <= 1'b0;
				cmd_latch <= 1'b0; write_strobe_n <= 1'b1;
				output_strobe_n <= !(ph_reg == 3'd1);
				ph_reg <= strobe_end ? 3'd0 : ph_reg + 3'd1;
				if (strobe_end)
				begin
					rd_byte <= io_in; rd_valid <= (st_reg == S_RDAT);
					if (st_reg == S_STAT)
					begin
						op_fail <= io_in[`NPB_STAT_FAIL_BIT];
						cmd_done_reg <= 1'b0; st_reg <= S_CEH;
					end
					else if (op_reg == OP_SCAN)
					begin
						// erased marker is all ones; block zero is always good
						blk_bad <= (io_in != `NPB_ERASED) &&
							(addr_reg[23:8] != `NPB_BLK_ZERO);
						st_reg <= S_CEH;
					end
					else if (len_reg <= 10'd1) st_reg <= S_CEH;
					else len_reg <= len_reg - 10'd1;
				end
			end
			S_WDAT:
			begin
				// address latch falls a cycle after the last address strobe
				addr_latch <= 1'b0;
				io_oe_n <= 1'b0; io_out <= wr_byte;
				write_strobe_n <= !(ph_reg == 3'd1);
				ph_reg <= strobe_end ? 3'd0 : ph_reg + 3'd1;
				if (strobe_end)
				begin
					wr_take <= 1'b1;
					if (len_reg <= 10'd1) st_reg <= S_CONF;
					else len_reg <= len_reg - 10'd1;
				end
			end
			S_CEH, S_ABORT:
			begin
				// select high long enough to break sequential read
				chip_en_n <= 1'b1; output_strobe_n <= 1'b1; io_oe_n <= 1'b1;
				tmr_reg <= tmr_reg + 16'd1;
				if (tmr_reg >= ((st_reg == S_ABORT) ? CRY_CYC + CEH_CYC : CEH_CYC))
					st_reg <= S_DONE;
			end
			S_DONE:
			begin
				// area B is one-shot; A and C persist in the flash
				op_busy <= 1'b0; op_done <= 1'b1; st_reg <= S_IDLE;
			end
			default: st_reg <= S_IDLE;
			endcase
		end
	end
endmodule

//--- tb/npb_host_asserts.sv
// checker on the host flash pins
// bound to npb_host, sees its ports only
`timescale 1ns/1ps
module npb_chk (
	input wire        ref_clk,
	input wire        rstn,
	input wire [2:0]  op_code,
	input wire [1:0]  op_area,
	input wire [31:0] op_addr,
	input wire        op_done,
	input wire        blk_bad,
	input wire        chip_en_n,
	input wire        cmd_latch,
	input wire        write_strobe_n,
	input wire [7:0]  io_out,
	input wire        ready_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// select high for over 100 ns
	property p_ceh; $rose(chip_en_n) |-> chip_en_n[*8] ##1 chip_en_n[*3]; endproperty
	a_ceh: assert property (p_ceh) else $error("select high too short");
	// busy allows status or reset only
	property p_bsy; cmd_latch && !write_strobe_n && !ready_busy
		|-> io_out == 8'h70 || io_out == 8'hFF; endproperty
	a_bsy: assert property (p_bsy) else $error("command while busy");
	property p_era; cmd_latch && !write_strobe_n |-> io_out != 8'h60; endproperty
	a_era: assert property (p_era) else $error("erase issued");
	property p_bk0; op_done && op_code == 3'h3 && op_addr[23:8] == 16'h0000 |-> !blk_bad; endproperty
	a_bk0: assert property (p_bk0) else $error("block zero reported bad");
	// second-half pointer right before program
	property p_ptb; cmd_latch && !write_strobe_n && io_out == 8'h80 && op_area == 2'h1
		|-> $past(io_out, 3) == 8'h01; endproperty
	a_ptb: assert property (p_ptb) else $error("pointer not before program");
	property p_sel; cmd_latch && !write_strobe_n |-> !chip_en_n; endproperty
	a_sel: assert property (p_sel) else $error("command without select");
endmodule
bind npb_host npb_chk chk_inst (.ref_clk(ref_clk), .rstn(rstn), .op_code(op_code),
	.op_area(op_area), .op_addr(op_addr), .op_done(op_done), .blk_bad(blk_bad),
	.chip_en_n(chip_en_n), .cmd_latch(cmd_latch), .write_strobe_n(write_strobe_n),
	.io_out(io_out), .ready_busy(ready_busy));

//--- tb/npb_flash_model.sv
// behavioural flash: pointers, busy times, invalid-block marker
// ready line pulled up when idle; strobes from the host
`timescale 1ns/1ps
module npb_flash_model #(
	parameter FB = 40,
	parameter PB = 30
) (
	input  wire       chip_en_n,
	input  wire       cmd_latch,
	input  wire       addr_latch,
	input  wire       write_strobe_n,
	input  wire       output_strobe_n,
	input  wire [7:0] io_out,
	output wire [7:0] io_in,
	output wire       ready_busy,
	input  wire       bad_mark,
	input  wire       prog_fail,
	input  wire       slow
);
	reg [7:0] last = 8'hFF;
	reg [7:0] oq = 8'h5A;
	reg       nz = 1'b0;
	reg       fetch = 1'b0;
	integer   col = 0;
	integer   base = 0;
	integer   na = 0;
	integer   left = 0;
	// busy timer in 10 ns steps
	assign ready_busy = (left == 0);
	assign io_in = oq;
	always #10 if (left > 0) left = left - 1;
	// commands, address and load cycles
	always @(posedge write_strobe_n)
		if (!chip_en_n && cmd_latch)
		begin
			last = io_out;
			na = 0;
			fetch = 1'b0;
			if (io_out == 8'h00 || io_out == 8'h50) base = io_out[4] ? 512 : 0;
			if (io_out == 8'h01) base = 256;
			if (io_out == 8'h10) left = PB;
			if (io_out == 8'hFF) left = 10;
			if ((io_out == 8'h10 || io_out == 8'hFF) && base == 256) base = 0;
			if (io_out == 8'h70) oq = {7'h00, prog_fail};
		end
		else if (!chip_en_n && addr_latch)
		begin
			if (na == 0) col = base + ((base == 512) ? io_out[3:0] : io_out);
			nz = (na == 0) ? 1'b0 : (nz | ((na < 3) && (io_out != 8'h00)));
			na = na + 1;
			if (na == 4 && last != 8'h80) left = slow ? 4 * FB : FB;
			if (na == 4 && last != 8'h80) fetch = 1'b1;
			if (na == 4 && base == 256) base = 0;
		end
		else if (!chip_en_n)
			col = col + 1;
	// released bus flips; select high aborts a fetch
	always @(posedge chip_en_n)
	begin
		oq = ~oq;
		if (fetch) left = 0;
	end
	// page bytes; spare erased except marker off block zero
	always @(negedge output_strobe_n)
		if (!chip_en_n && last != 8'h70)
		begin
			oq = (col < 512) ? (col[7:0] ^ {col[8], 7'h00}) : ((col == 517 && bad_mark && nz) ? 8'h00 : 8'hFF);
			col = col + 1;
		end
endmodule

//--- tb/npb_host_tb.sv
// bench: host sequencer against the flash model
// checker bound from its own file
`timescale 1ns/1ps
module npb_host_tb;
	reg         ref_clk = 1'b0;
	reg         rstn = 1'b0;
	reg         op_start = 1'b0;
	reg  [2:0]  op_code = 3'h0;
	reg  [1:0]  op_area = 2'h0;
	reg  [31:0] op_addr = 32'h0;
	reg  [9:0]  op_len = 10'h1;
	reg         bad_mark = 1'b0;
	reg         prog_fail = 1'b0;
	reg         slow = 1'b0;
	reg  [7:0]  got [0:3];
	integer     n, w, error_cnt = 0, tests_run = 0;
	wire [7:0]  rd_byte, io_out, io_in;
	wire        wr_take, rd_valid, op_busy, op_done, op_fail, blk_bad, chip_en_n, io_oe_n;
	wire        cmd_latch, addr_latch, write_strobe_n, output_strobe_n, ready_busy;
	npb_host #(.FETCH_CYC(50)) npb_host_inst (.ref_clk(ref_clk), .rstn(rstn),
		.op_start(op_start), .op_code(op_code), .op_area(op_area), .op_addr(op_addr),
		.op_len(op_len), .wr_byte(8'hA5), .wr_take(wr_take), .rd_byte(rd_byte),
		.rd_valid(rd_valid), .op_busy(op_busy), .op_done(op_done), .op_fail(op_fail),
		.blk_bad(blk_bad), .chip_en_n(chip_en_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.output_strobe_n(output_strobe_n), .io_out(io_out), .io_oe_n(io_oe_n),
		.io_in(io_in), .ready_busy(ready_busy));
	npb_flash_model npb_flash_model_inst (.chip_en_n(chip_en_n), .cmd_latch(cmd_latch),
		.addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
		.output_strobe_n(output_strobe_n), .io_out(io_out), .io_in(io_in),
		.ready_busy(ready_busy), .bad_mark(bad_mark), .prog_fail(prog_fail),
		.slow(slow));
	initial forever #5 ref_clk = ~ref_clk;
	task chk(input [8*4:1] nm, input [7:0] e, input [7:0] g);
	begin
		tests_run = tests_run + 1;
		if (g !== e)
		begin
			error_cnt = error_cnt + 1;
			$display("BAD %0s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// one operation, collecting read bytes until done
	task run(input [2:0] c, input [1:0] a, input [31:0] ad, input [9:0] l);
		integer k;
	begin
		@(posedge ref_clk);
		{op_code, op_area, op_addr, op_len, op_start} <= {c, a, ad, l, 1'b1};
		@(posedge ref_clk);
		op_start <= 1'b0;
		n = 0;
		w = 0;
		for (k = 0; k < 3000 && op_done !== 1'b1; k = k + 1)
		begin
			@(posedge ref_clk);
			#1;
			if (rd_valid === 1'b1 && n < 4) got[n] = rd_byte;
			if (rd_valid === 1'b1) n = n + 1;
			if (wr_take === 1'b1) w = w + 1;
		end
		chk("done", 8'h01, {7'h00, op_done});
		chk("bsy", 8'h00, {7'h00, op_busy});
		chk("oen", 8'h01, {7'h00, io_oe_n});
	end
	endtask
	task t_read;
	begin
		run(3'h0, 2'h0, 32'h00000103, 10'h2);
		chk("cnt", 8'h02, n[7:0]);
		chk("a0", 8'h03, got[0]);
		chk("a1", 8'h04, got[1]);
		run(3'h0, 2'h1, 32'h00000102, 10'h1);
		chk("b0", 8'h82, got[0]);
		run(3'h0, 2'h2, 32'h00000103, 10'h1);
		chk("c0", 8'hFF, got[0]);
	end
	endtask
	task t_scan;
	begin
		bad_mark = 1'b1;
		run(3'h3, 2'h2, 32'h00000100, 10'h1);
		chk("bad", 8'h01, {7'h00, blk_bad});
		run(3'h3, 2'h2, 32'h00000000, 10'h1);
		chk("bk0", 8'h00, {7'h00, blk_bad});
		bad_mark = 1'b0;
		run(3'h3, 2'h2, 32'h00000200, 10'h1);
		chk("good", 8'h00, {7'h00, blk_bad});
	end
	endtask
	task t_prog;
	begin
		prog_fail = 1'b1;
		run(3'h1, 2'h1, 32'h00000102, 10'h2);
		chk("pf", 8'h01, {7'h00, op_fail});
		chk("wr", 8'h02, w[7:0]);
		prog_fail = 1'b0;
		run(3'h1, 2'h0, 32'h00000102, 10'h2);
		chk("pok", 8'h00, {7'h00, op_fail});
		chk("wr", 8'h02, w[7:0]);
		run(3'h2, 2'h0, 32'h00000000, 10'h0);
		chk("rst", 8'h00, {7'h00, op_fail});
	end
	endtask
	// fetch outlasting its bound is cut by raising select
	task t_abort;
	begin
		slow = 1'b1;
		run(3'h0, 2'h0, 32'h00000103, 10'h1);
		chk("abt", 8'h01, {7'h00, op_fail});
		chk("nrd", 8'h00, n[7:0]);
		chk("rdy", 8'h01, {7'h00, ready_busy});
		slow = 1'b0;
	end
	endtask
	task end_sim;
	begin
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		#300000;
		error_cnt = error_cnt + 1;
		end_sim;
	end
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		t_read;
		t_scan;
		t_prog;
		t_abort;
		end_sim;
	end
endmodule
